// >>> include/ack_timer_if.sv
// Link between the bus unit and its external-master acknowledge timer.
// Assumes both ends run on the same system clock.
interface ack_timer_if;
    logic start;
    logic [3:0] waits;
    logic autoAck;
    logic isDram;
    logic fire;
    modport ctrl (output start, waits, autoAck, isDram, input fire);
    modport timer (input start, waits, autoAck, isDram, output fire);
endinterface

// >>> include/ext_bus_pkg.sv
// Shared constants and state types for the external bus unit.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
package ext_bus_pkg;
    // Transfer size codes on the size lines
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;
    // Access type codes
    localparam logic [1:0] TYPE_NORMAL = 2'h0;
    localparam logic [1:0] TYPE_DMA = 2'h1;
    localparam logic [1:0] TYPE_DEBUG = 2'h2;
    localparam logic [1:0] TYPE_CPU = 2'h3;
    // Interrupt acknowledge address pattern
    localparam logic [22:0] IACK_HIGH = 23'h7FFFFF;
    localparam logic [1:0] IACK_LOW = 2'h0;
    // Byte lane patterns
    localparam logic [3:0] LANES_ALL = 4'hF;
    localparam logic [3:0] LANES_HI = 4'hC;
    localparam logic [3:0] LANES_LO = 4'h3;
    localparam logic [3:0] LANE_TOP = 4'h8;
    // Fixed DRAM completion time, rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int DRAM_DONE_NS = 30;
    localparam logic [7:0] DRAM_DONE_CYC =
        8'((DRAM_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef enum logic [1:0] {M_IDLE, M_START, M_WAIT} mst_state_t;
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ACK, S_NEG} slv_state_t;
endpackage

// >>> rtl/ack_sync.sv
// Two-stage synchroniser for the asynchronous done acknowledge.
// Assumes the pin is active low and may change at any time.
module ack_sync
    import ext_bus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic asyncDoneAckN,
    output logic ackSynced
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_t;
    sync_t s_r;
    sync_t s_nxt;

    // First stage feeds only the second stage
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = asyncDoneAckN;
        s_nxt.s2 = s_r.s1;
        if (rst) begin
            s_nxt = '1;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_r <= s_nxt;
    end

    assign ackSynced = ~s_r.s2;
endmodule

// >>> rtl/ext_bus_unit.sv
// External bus unit: runs own bus cycles and snoops external-master cycles.
// Assumes bus grant changes only while no own cycle runs; pins resolved outside.
module ext_bus_unit
    import ext_bus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic busGranted,
    input wire logic reqValid,
    input wire logic [31:0] reqAddr,
    input wire logic reqRead,
    input wire logic [1:0] reqSize,
    input wire logic [1:0] reqType,
    input wire logic reqCode,
    input wire logic reqSuper,
    input wire logic reqIack,
    input wire logic [2:0] reqIntLevel,
    input wire logic reqDram,
    input wire logic [31:0] reqWdata,
    input wire logic [3:0] pinAssignField,
    input wire logic [3:0] cfgWaitStates,
    input wire logic cfgAutoAck,
    input wire logic [27:0] dramBase,
    input wire logic [27:0] dramMask,
    output logic coreReady,
    output logic rspValid,
    output logic rspError,
    output logic [31:0] rspData,
    output logic [27:0] addrOut,
    output logic addrLoOe,
    output logic [3:0] addrHiOe,
    input wire logic [27:0] addrIn,
    output logic [31:0] dataOut,
    output logic dataOe,
    input wire logic [31:0] dataIn,
    output logic cycleBeginStrobeOutN,
    input wire logic cycleBeginStrobeInN,
    output logic rwOut,
    input wire logic rwIn,
    output logic [1:0] xferSizeCodeOut,
    input wire logic [1:0] xferSizeCodeIn,
    output logic ctrlOe,
    output logic [1:0] accessTypeCode,
    output logic accessModeBit,
    output logic attrOe,
    input wire logic asyncDoneAckN,
    input wire logic syncDoneAckInN,
    output logic syncDoneAckOutN,
    output logic syncDoneAckOe,
    input wire logic errorDoneAckN,
    output logic extSelect,
    output logic extDramSel,
    output logic extRead,
    output logic [3:0] extLanes
);
    typedef struct packed {
        mst_state_t mst;
        slv_state_t slv;
        logic [27:0] addr;
        logic addrLoOe;
        logic [3:0] addrHiOe;
        logic [31:0] dOut;
        logic dOe;
        logic strobeN;
        logic rw;
        logic [1:0] size;
        logic ctrlOe;
        logic [1:0] typeCode;
        logic modeBit;
        logic modeLate;
        logic attrOe;
        logic isDram;
        logic [7:0] cnt;
        logic rspValid;
        logic rspError;
        logic [31:0] rspData;
        logic ackN;
        logic ackOe;
        logic extSelect;
        logic extDramSel;
        logic extRead;
        logic [3:0] extLanes;
        logic ready;
    } unit_t;
    unit_t s_r;
    unit_t s_nxt;
    logic ataSynced;
    logic extStart;
    logic dramHit;
    logic endNow;
    ack_timer_if tmr ();

    // Mode bit shown while the start strobe is low
    function automatic logic firstMode(logic [1:0] t, logic code, logic iack);
        case (t)
            TYPE_DMA: firstMode = 1'b1;
            TYPE_CPU: firstMode = iack;
            default: firstMode = code;
        endcase
    endfunction

    // Mode bit shown in the cycles after the strobe
    function automatic logic lateMode(logic [1:0] t, logic sup);
        lateMode = (t == TYPE_NORMAL || t == TYPE_DEBUG) ? sup : 1'b0;
    endfunction

    // Byte lanes that a master transfer touches
    function automatic logic [3:0] laneEnable(logic [1:0] sz, logic [1:0] a);
        case (sz)
            SIZE_BYTE: laneEnable = LANE_TOP >> a;
            SIZE_WORD: laneEnable = a[1] ? LANES_LO : LANES_HI;
            default: laneEnable = LANES_ALL;
        endcase
    endfunction

    ack_sync i_ack_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncDoneAckN(asyncDoneAckN),
        .ackSynced(ataSynced)
    );

    slave_ack_timer i_slave_ack_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .tmr(tmr.timer)
    );

    // Snoop decode: only address, direction and size are looked at
    assign extStart = !cycleBeginStrobeInN && !busGranted && s_r.slv == S_IDLE;
    assign dramHit = ((addrIn ^ dramBase) & dramMask) == 28'h0000000;
    assign tmr.start = extStart;
    assign tmr.waits = cfgWaitStates;
    assign tmr.autoAck = cfgAutoAck;
    assign tmr.isDram = dramHit;

    // Own cycle ends by the fixed DRAM count or by the acknowledge pins
    always_comb begin
        endNow = 1'b0;
        if (s_r.mst != M_IDLE) begin
            if (s_r.isDram) begin
                endNow = s_r.cnt == 8'h00;
            end else begin
                endNow = !errorDoneAckN || !syncDoneAckInN || ataSynced;
            end
        end
    end

    // Next state for both the master and the snoop side
    always_comb begin
        s_nxt = s_r;
        s_nxt.rspValid = 1'b0;
        s_nxt.rspError = 1'b0;
        s_nxt.strobeN = 1'b1;
        case (s_r.mst)
            M_IDLE: begin
                if (reqValid && busGranted) begin
                    s_nxt.mst = M_START;
                    s_nxt.strobeN = 1'b0;
                    s_nxt.ctrlOe = 1'b1;
                    s_nxt.attrOe = 1'b1;
                    s_nxt.rw = reqRead;
                    s_nxt.size = reqSize;
                    s_nxt.typeCode = reqType;
                    s_nxt.isDram = reqDram;
                    s_nxt.cnt = DRAM_DONE_CYC;
                    s_nxt.addr = reqIack ? {IACK_HIGH, reqIntLevel, IACK_LOW}
                                         : reqAddr[27:0];
                    s_nxt.addrLoOe = 1'b1;
                    s_nxt.addrHiOe = pinAssignField;
                    s_nxt.dOut = reqWdata;
                    s_nxt.dOe = !reqRead;
                    s_nxt.modeBit = firstMode(reqType, reqCode, reqIack);
                    s_nxt.modeLate = lateMode(reqType, reqSuper);
                end
            end
            M_START: begin
                s_nxt.mst = M_WAIT;
                s_nxt.modeBit = s_r.modeLate;
            end
            M_WAIT: begin
                if (s_r.isDram) begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            default: s_nxt.mst = M_IDLE;
        endcase
        // Termination; error wins and no data is taken on it
        if (endNow) begin
            s_nxt.mst = M_IDLE;
            s_nxt.rspValid = 1'b1;
            s_nxt.rspError = !s_r.isDram && !errorDoneAckN;
            if (s_r.rw && (s_r.isDram || errorDoneAckN)) begin
                s_nxt.rspData = dataIn;
            end
            s_nxt.addrLoOe = 1'b0;
            s_nxt.addrHiOe = 4'h0;
            s_nxt.dOe = 1'b0;
            s_nxt.ctrlOe = 1'b0;
            s_nxt.attrOe = 1'b0;
        end
        // Snoop side; type and mode lines are never looked at here
        case (s_r.slv)
            S_IDLE: begin
                s_nxt.extSelect = 1'b0;
                s_nxt.extDramSel = 1'b0;
                if (extStart) begin
                    s_nxt.extRead = rwIn;
                    s_nxt.extLanes = laneEnable(xferSizeCodeIn, addrIn[1:0]);
                    s_nxt.extSelect = !dramHit;
                    s_nxt.extDramSel = dramHit;
                    if (dramHit || cfgAutoAck) begin
                        s_nxt.slv = S_WAIT;
                    end
                end
            end
            S_WAIT: begin
                if (tmr.fire) begin
                    s_nxt.slv = S_ACK;
                    s_nxt.ackN = 1'b0;
                    s_nxt.ackOe = 1'b1;
                end
            end
            S_ACK: begin
                s_nxt.slv = S_NEG;
                s_nxt.ackN = 1'b1;
            end
            S_NEG: begin
                s_nxt.slv = S_IDLE;
                s_nxt.ackOe = 1'b0;
                s_nxt.extSelect = 1'b0;
                s_nxt.extDramSel = 1'b0;
            end
            default: s_nxt.slv = S_IDLE;
        endcase
        if (rst) begin
            s_nxt = '0;
            s_nxt.strobeN = 1'b1;
            s_nxt.ackN = 1'b1;
        end
        s_nxt.ready = s_nxt.mst == M_IDLE; // Registered so the ready pin has no decode
    end

    always_ff @(posedge clk_sys) begin
        s_r <= s_nxt;
    end

    // Every output straight from the state register
    assign coreReady = s_r.ready;
    assign rspValid = s_r.rspValid;
    assign rspError = s_r.rspError;
    assign rspData = s_r.rspData;
    assign addrOut = s_r.addr;
    assign addrLoOe = s_r.addrLoOe;
    assign addrHiOe = s_r.addrHiOe;
    assign dataOut = s_r.dOut;
    assign dataOe = s_r.dOe;
    assign cycleBeginStrobeOutN = s_r.strobeN;
    assign rwOut = s_r.rw;
    assign xferSizeCodeOut = s_r.size;
    assign ctrlOe = s_r.ctrlOe;
    assign accessTypeCode = s_r.typeCode;
    assign accessModeBit = s_r.modeBit;
    assign attrOe = s_r.attrOe;
    assign syncDoneAckOutN = s_r.ackN;
    assign syncDoneAckOe = s_r.ackOe;
    assign extSelect = s_r.extSelect;
    assign extDramSel = s_r.extDramSel;
    assign extRead = s_r.extRead;
    assign extLanes = s_r.extLanes;

    // Checks tied to the bus behaviour
    logic take;
    assign take = reqValid && busGranted && coreReady;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_iack_addr;
        take && reqIack |=> addrOut[27:5] == IACK_HIGH && addrOut[1:0] == IACK_LOW
            && addrOut[4:2] == $past(reqIntLevel);
    endproperty
    a_iack_addr: assert property (p_iack_addr) else $error("iack address wrong");
    property p_hi_addr;
        take |=> addrHiOe == $past(pinAssignField) && addrLoOe;
    endproperty
    a_hi_addr: assert property (p_hi_addr) else $error("address enables wrong");
    property p_write_data;
        take && !reqRead |=> dataOe && dataOut == $past(reqWdata);
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data not driven");
    property p_strobe_once;
        take |=> !cycleBeginStrobeOutN ##1 cycleBeginStrobeOutN;
    endproperty
    a_strobe_once: assert property (p_strobe_once) else $error("strobe not one clock");
    property p_dir_type;
        take |=> rwOut == $past(reqRead) && accessTypeCode == $past(reqType) && ctrlOe;
    endproperty
    a_dir_type: assert property (p_dir_type) else $error("direction or type wrong");
    property p_mode_normal;
        take && reqType == TYPE_NORMAL |=> accessModeBit == $past(reqCode)
            ##1 accessModeBit == $past(reqSuper, 2);
    endproperty
    a_mode_normal: assert property (p_mode_normal) else $error("mode bit wrong");
    property p_mode_dma;
        take && reqType == TYPE_DMA |=> accessModeBit ##1 !accessModeBit;
    endproperty
    a_mode_dma: assert property (p_mode_dma) else $error("dma mode bit wrong");

    property p_async_read;
        s_r.mst == M_WAIT && !s_r.isDram && s_r.rw && ataSynced && errorDoneAckN
            |=> rspValid && !rspError && rspData == $past(dataIn);
    endproperty
    a_async_read: assert property (p_async_read) else $error("async read not latched");

    property p_dram_ignore;
        s_r.mst == M_WAIT && s_r.isDram && s_r.cnt != 8'h00 |=> !rspValid;
    endproperty
    a_dram_ignore: assert property (p_dram_ignore) else $error("dram ended early");

    property p_error_first;
        s_r.mst != M_IDLE && !s_r.isDram && !errorDoneAckN |=> rspValid && rspError;
    endproperty
    a_error_first: assert property (p_error_first) else $error("error not taken");

    property p_ack_release;
        syncDoneAckOe && !syncDoneAckOutN |=> syncDoneAckOe && syncDoneAckOutN
            ##1 !syncDoneAckOe;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack release wrong");

    property p_dram_ack;
        extStart && dramHit |-> ##[3:12] !syncDoneAckOutN;
    endproperty
    a_dram_ack: assert property (p_dram_ack) else $error("dram ack missing");

    property p_release;
        !busGranted && coreReady |=> !ctrlOe && !dataOe && !addrLoOe && !attrOe;
    endproperty
    a_release: assert property (p_release) else $error("lines not released");
endmodule

// >>> rtl/slave_ack_timer.sv
// Wait-state timer that decides when an external-master cycle is acknowledged.
// Assumes start is a one-cycle pulse, never given while a count runs.
module slave_ack_timer
    import ext_bus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    ack_timer_if.timer tmr
);
    typedef struct packed {
        logic [7:0] cnt;
        logic busy;
        logic fire;
    } timer_t;
    timer_t s_r;
    timer_t s_nxt;

    // Count down the programmed or fixed wait, then pulse fire
    always_comb begin
        s_nxt = s_r;
        s_nxt.fire = 1'b0;
        if (tmr.start && tmr.isDram) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = DRAM_DONE_CYC;
        end else if (tmr.start && tmr.autoAck) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = {4'h0, tmr.waits};
        end else if (s_r.busy && s_r.cnt == 8'h00) begin
            s_nxt.busy = 1'b0;
            s_nxt.fire = 1'b1;
        end else if (s_r.busy) begin
            s_nxt.cnt = s_r.cnt - 8'h01;
        end
        if (rst) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_r <= s_nxt;
    end

    assign tmr.fire = s_r.fire;
endmodule

// >>> verif/bus_slave_model.sv
// Behavioural slave that answers the bus unit's own cycles.
// Assumes resolved pin levels from the bench and the shared system clock.
module bus_slave_model (
    input wire logic clk_sys,
    input wire logic strobeN,
    input wire logic strobeOe,
    input wire logic [1:0] ackKind,
    input wire logic [1:0] ackDelay,
    input wire logic [31:0] rdWord,
    output logic syncAckN,
    output logic asyncAckN,
    output logic errAckN,
    output logic [31:0] rdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] kind;
    logic [31:0] word;

    // Kind 0 sync, 1 async, 2 error; pins move 1 ns after an edge
    initial begin
        syncAckN = 1'b1;
        asyncAckN = 1'b1;
        errAckN = 1'b1;
        rdData = 32'h0;
        forever begin
            @(posedge clk_sys);
            if (strobeOe === 1'b1 && strobeN === 1'b0) begin
                kind = ackKind;
                word = rdWord;
                #1;
                repeat (ackDelay) begin
                    @(posedge clk_sys);
                    #1;
                end
                rdData = word;
                syncAckN = (kind != 2'h0);
                asyncAckN = (kind != 2'h1);
                errAckN = (kind != 2'h2);
                @(posedge clk_sys);
                #1;
                syncAckN = 1'b1;
                errAckN = 1'b1;
                // Async ack held two clocks so the synchroniser cannot miss it
                if (kind == 2'h1) begin
                    @(posedge clk_sys);
                    #1;
                    asyncAckN = 1'b1;
                end
                @(posedge clk_sys);
                #1;
                // Released bus: no keeper, so show a changed value
                rdData = ~word;
            end
        end
    end
endmodule

// >>> verif/external_bus_signal_interface_test.sv
// Self-checking bench for the external bus unit: own cycles and snooping.
// Assumes the slave model above; the bench plays the external master.
module external_bus_signal_interface_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ext_bus_pkg::*;
    typedef struct packed {logic err; logic chk; logic [31:0] d;} note_t;
    logic clk_sys = 1'b0, rst = 1'b1, busGranted = 1'b1, reqValid = 1'b0, reqRead = 1'b0;
    logic reqCode = 1'b0, reqSuper = 1'b0, reqIack = 1'b0, reqDram = 1'b0, cfgAutoAck = 1'b0;
    logic [31:0] reqAddr = 32'h0, reqWdata = 32'h0, rdWord = 32'h0;
    logic [1:0] reqSize = 2'h0, reqType = 2'h0, ackKind = 2'h0, ackDelay = 2'h0;
    logic [2:0] reqIntLevel = 3'h0;
    logic [3:0] pinAssignField = 4'h0, cfgWaitStates = 4'h0;
    logic [27:0] dramBase = 28'h0400000, dramMask = 28'hFC00000, mAddr = 28'h0;
    logic mStrobeN = 1'b1, mRw = 1'b1;
    logic [1:0] mSize = 2'h0;
    logic coreReady, rspValid, rspError, addrLoOe, dataOe, cycleBeginStrobeOutN, rwOut;
    logic ctrlOe, accessModeBit, attrOe, asyncDoneAckN, syncDoneAckOutN, syncDoneAckOe;
    logic errorDoneAckN, extSelect, extDramSel, extRead, slvSyncN;
    logic [31:0] rspData, dataOut, slvData;
    logic [27:0] addrOut;
    logic [3:0] addrHiOe, extLanes;
    logic [1:0] xferSizeCodeOut, accessTypeCode;
    wire logic [27:0] addrIn;
    wire logic [31:0] dataIn;
    wire logic cycleBeginStrobeInN, rwIn, syncDoneAckInN;
    wire logic [1:0] xferSizeCodeIn;
    note_t notes[$];
    note_t cur;
    int mismatches = 0;
    int checks = 0;

    always #5 clk_sys = ~clk_sys;

    // Wire levels from whichever party enables its driver
    assign cycleBeginStrobeInN = ctrlOe ? cycleBeginStrobeOutN : mStrobeN;
    assign rwIn = ctrlOe ? rwOut : mRw;
    assign xferSizeCodeIn = ctrlOe ? xferSizeCodeOut : mSize;
    assign addrIn = addrLoOe ? addrOut : mAddr;
    assign dataIn = dataOe ? dataOut : slvData;
    assign syncDoneAckInN = syncDoneAckOe ? syncDoneAckOutN : slvSyncN;

    ext_bus_unit i_ext_bus_unit (
        .clk_sys, .rst, .busGranted, .reqValid, .reqAddr, .reqRead, .reqSize, .reqType,
        .reqCode, .reqSuper, .reqIack, .reqIntLevel, .reqDram, .reqWdata, .pinAssignField,
        .cfgWaitStates, .cfgAutoAck, .dramBase, .dramMask, .coreReady, .rspValid, .rspError,
        .rspData, .addrOut, .addrLoOe, .addrHiOe, .addrIn, .dataOut, .dataOe, .dataIn,
        .cycleBeginStrobeOutN, .cycleBeginStrobeInN, .rwOut, .rwIn, .xferSizeCodeOut,
        .xferSizeCodeIn, .ctrlOe, .accessTypeCode, .accessModeBit, .attrOe, .asyncDoneAckN,
        .syncDoneAckInN, .syncDoneAckOutN, .syncDoneAckOe, .errorDoneAckN, .extSelect,
        .extDramSel, .extRead, .extLanes
    );

    bus_slave_model i_bus_slave_model (
        .clk_sys, .strobeN(cycleBeginStrobeOutN), .strobeOe(ctrlOe), .ackKind, .ackDelay,
        .rdWord, .syncAckN(slvSyncN), .asyncAckN(asyncDoneAckN), .errAckN(errorDoneAckN),
        .rdData(slvData)
    );

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Byte lanes of a master cycle, big-endian lane order
    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] lo);
        case (sz)
            SIZE_BYTE: return LANE_TOP >> lo;
            SIZE_WORD: return lo[1] ? LANES_LO : LANES_HI;
            default: return LANES_ALL;
        endcase
    endfunction

    // Oldest note is matched against each completed own cycle
    always @(negedge clk_sys) begin
        if (rspValid === 1'b1) begin
            if (notes.size() == 0) begin
                check_val(1, 0, "unexpected response");
            end else begin
                cur = notes.pop_front();
                check_val(rspError, cur.err, "error end");
                if (cur.chk) check_val(rspData, cur.d, "read data");
            end
        end
    end

    // One own cycle; pins checked in the strobe cycle and the one after
    task automatic own(input logic rd, input logic [1:0] typ, input logic [1:0] sz,
            input logic iack, input logic [2:0] lvl, input logic dram, input logic [1:0] kind);
        logic first;
        logic late;
        logic [27:0] expAddr;
        int n;
        @(negedge clk_sys);
        {reqRead, reqType, reqSize, reqIack, reqIntLevel, reqDram} = {rd, typ, sz, iack, lvl, dram};
        reqAddr = $urandom();
        reqWdata = $urandom();
        rdWord = $urandom();
        {reqCode, reqSuper, ackDelay, pinAssignField} = 8'($urandom());
        ackKind = kind;
        reqValid = 1'b1;
        first = (typ == TYPE_CPU) ? iack : ((typ == TYPE_DMA) ? 1'b1 : reqCode);
        late = (typ == TYPE_NORMAL || typ == TYPE_DEBUG) ? reqSuper : 1'b0;
        expAddr = iack ? {IACK_HIGH, lvl, IACK_LOW} : reqAddr[27:0];
        notes.push_back('{err: kind == 2'h2 && !dram, chk: rd && kind != 2'h2 && !dram, d: rdWord});
        n = 0;
        while (coreReady !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        reqValid = 1'b0;
        check_val(cycleBeginStrobeOutN, 0, "strobe");
        check_val({ctrlOe, attrOe, addrLoOe, addrHiOe}, {3'h7, pinAssignField}, "enables");
        check_val(addrOut, expAddr, "address");
        check_val({rwOut, xferSizeCodeOut, accessTypeCode}, {rd, sz, typ}, "ctrl");
        check_val(accessModeBit, first, "mode first");
        if (!rd) check_val({dataOe, dataOut}, {1'b1, reqWdata}, "write data");
        @(negedge clk_sys);
        check_val(cycleBeginStrobeOutN, 1, "strobe end");
        check_val(accessModeBit, late, "mode late");
        if (!rd) check_val(dataOe, 1, "write hold");
        if (dram) begin
            // Acks and errors from the slave must not shorten a DRAM cycle
            repeat (3) begin
                @(negedge clk_sys);
                check_val(rspValid, 0, "dram early");
            end
            @(negedge clk_sys);
            check_val(rspValid, 1, "dram end");
        end
    endtask

    // One external-master cycle; records the acknowledge pin per cycle
    task automatic snoop(input logic dram, input logic auto, input logic [3:0] ws);
        logic [1:0] seen[26];
        int hit;
        @(negedge clk_sys);
        {cfgAutoAck, cfgWaitStates} = {auto, ws};
        {mRw, mSize} = 3'($urandom());
        mAddr = {dram ? 6'h01 : 6'h20, 22'($urandom())};
        mStrobeN = 1'b0;
        @(negedge clk_sys);
        mStrobeN = 1'b1;
        check_val({extDramSel, extSelect, extRead}, {dram, ~dram, mRw}, "decode");
        check_val(extLanes, lanes(mSize, mAddr[1:0]), "lanes");
        check_val({ctrlOe, dataOe, addrLoOe, addrHiOe, attrOe}, 0, "released");
        hit = 0;
        for (int n = 2; n < 26; n++) begin
            @(negedge clk_sys);
            seen[n] = {syncDoneAckOe, syncDoneAckOutN};
            if (seen[n] === 2'b10 && hit == 0) hit = n;
        end
        check_val(hit, dram ? 6 : (auto ? ws + 3 : 0), "ack time");
        if (hit > 0) begin
            check_val(seen[hit + 1], 2'b11, "negated");
            check_val(seen[hit + 2][1], 0, "ack released");
        end
    endtask

    // Hang guard, far beyond the expected few hundred cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        mismatches++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h7CF42F49));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        check_val({coreReady, cycleBeginStrobeOutN, ctrlOe, dataOe, attrOe}, 5'h18, "reset");
        rst = 1'b0;
        // Every type and size, acknowledge kinds rotating
        for (int i = 0; i < 16; i++) begin
            own(i[0] ^ i[2], i[1:0], i[3:2], 1'b0, 3'h0, 1'b0, 2'(i % 3));
        end
        for (int l = 1; l < 8; l++) begin
            own(1'b1, TYPE_CPU, SIZE_BYTE, 1'b1, 3'(l), 1'b0, 2'(l % 3));
        end
        for (int k = 0; k < 3; k++) begin
            own(k[0], TYPE_NORMAL, SIZE_LONG, 1'b0, 3'h0, 1'b1, 2'(k));
        end
        repeat (8) @(negedge clk_sys);
        check_val(notes.size(), 0, "responses missing");
        busGranted = 1'b0;
        repeat (2) @(negedge clk_sys);
        snoop(1'b1, 1'b0, 4'h0);
        snoop(1'b0, 1'b1, 4'h0);
        snoop(1'b0, 1'b1, 4'($urandom()));
        snoop(1'b0, 1'b0, 4'h2);
        report_and_stop();
    end
endmodule
